// >>> ufe_pkg.sv
// Package for the USB error flag unit: register map, bit positions,
// reset values, timing constants and carrier structs.
// Assumes one 125 MHz clock and a full-speed (12 Mbps) bus.
package ufe_pkg;
  // ===========================================================
  // Register map (word index on the plain register port)
  localparam logic [3:0] ADDR_ERR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_ERR_ENAB  = 4'h1;
  localparam logic [3:0] ADDR_INT_STAT  = 4'h2;
  localparam logic [3:0] ADDR_INT_ENAB  = 4'h3;
  // ===========================================================
  // Field positions and values
  localparam int        BIT_PID      = 0;
  localparam int        BIT_TOKCRC   = 1;
  localparam int        BIT_DATCRC   = 2;
  localparam int        BIT_PARTBYTE = 3;
  localparam int        BIT_TURN     = 4;
  localparam int        BIT_BUF      = 5;
  localparam int        BIT_STUFF    = 7;
  localparam int        BIT_INT_ERR  = 1;
  localparam logic [7:0] ERR_IMPL_MASK = 8'hbf;
  localparam logic [7:0] INT_IMPL_MASK = 8'h02;
  localparam logic [7:0] ERR_FLAGS_RST = 8'h00;
  localparam logic [7:0] ERR_ENAB_RST  = 8'h00;
  localparam logic [7:0] INT_STAT_RST  = 8'h00;
  localparam logic [7:0] INT_ENAB_RST  = 8'h00;
  localparam logic [7:0] ZERO8         = 8'h00;
  // ===========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BIT_TIME_PS   = 83333;
  localparam int TURN_BITS     = 16;
  // Least time: round up to whole cycles
  localparam int TURN_CYCLES =
    (TURN_BITS * BIT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TURN_CNT_W = 9;
  localparam logic [TURN_CNT_W-1:0] TURN_CNT_ONE = 9'h001;
  localparam logic [TURN_CNT_W-1:0] TURN_CNT_ZERO = 9'h000;
  // ===========================================================
  // Carriers
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ufe_bus_req_t;
  typedef struct packed {
    logic bit_stuff;
    logic data_crc;
    logic token_crc;
    logic pid;
    logic partial_byte;
    logic bd_late;
  } ufe_det_t;
endpackage

// >>> ufe_error_flag_unit.sv
// USB error flag unit: sticky error flags, enables, the error bit of
// the USB interrupt status, turnaround timer and buffer size check.
// Assumes decoder pulses on clk, and the bus idle level from a pin.
`timescale 1ns/10ps
module ufe_error_flag_unit
  import ufe_pkg::*;
#(
  parameter int BD_SIZE_W = 10                // Descriptor size width
)
(
  input  wire logic                 clk,        // Module clock
  input  wire logic                 rst_b,      // Sync reset
  input  wire logic                 ce,         // Clock enable
  input  wire ufe_bus_req_t         bus_req,    // Register request
  output logic [7:0]                bus_rdata,  // Read data
  input  wire ufe_det_t             det,        // Decoder detections
  input  wire logic                 pkt_start,  // Data packet start
  input  wire logic                 rx_byte,    // Received byte strobe
  input  wire logic [BD_SIZE_W-1:0] bd_size,    // Descriptor size
  input  wire logic                 eop_seen,   // End of packet
  input  wire logic                 await_resp, // Reply phase expected
  input  wire logic                 line_idle,  // Bus idle, pin level
  output logic                      store_en,   // Byte may be stored
  output logic                      pkt_reject, // Drop data packet
  output logic                      tok_reject, // Drop token
  output logic                      irq         // Interrupt request
);

  // ===========================================================
  // Local functions

  // One-hot word for a bit position
  function automatic logic [7:0] bit_of(input int pos);
    logic [7:0] v;
    v = ZERO8;
    v[pos] = 1'b1;
    return v;
  endfunction

  // Write-one-to-clear with set winning over clear
  function automatic logic [7:0] w1c_next(
    input logic [7:0] cur,
    input logic [7:0] clr,
    input logic [7:0] set,
    input logic [7:0] impl
  );
    return ((cur & ~clr) | set) & impl;
  endfunction

  // ===========================================================
  // Registers and internal state

  logic [7:0]            err_flags_reg;
  logic [7:0]            err_flags_next;
  logic [7:0]            err_enab_reg;
  logic [7:0]            int_stat_reg;
  logic [7:0]            int_stat_next;
  logic [7:0]            int_enab_reg;
  logic [7:0]            err_set;
  logic [7:0]            flag_clr;
  logic [7:0]            int_clr;
  logic [7:0]            int_set;
  logic [BD_SIZE_W-1:0]  byte_cnt_reg;
  logic                  oversize;
  logic                  turn_fault;
  logic                  wr_flags;
  logic                  wr_int;
  logic                  idle_s1_reg;
  logic                  idle_s2_reg;
  logic                  idle_s3_reg;
  logic                  idle_reg;
  logic                  idle_q_reg;
  logic                  idle_fall;
  logic [TURN_CNT_W-1:0] turn_cnt_reg;

  typedef enum logic [2:0] {
    TURN_OFF   = 3'b001,
    TURN_ARMED = 3'b010,
    TURN_DONE  = 3'b100
  } ufe_turn_t;

  ufe_turn_t turn_state_reg;

  // ===========================================================
  // Write decode

  // Register writes are single-cycle strobes
  assign wr_flags = bus_req.wr && (bus_req.addr == ADDR_ERR_FLAGS);
  assign wr_int   = bus_req.wr && (bus_req.addr == ADDR_INT_STAT);
  assign flag_clr = wr_flags ? bus_req.wdata : ZERO8;
  assign int_clr  = wr_int ? bus_req.wdata : ZERO8;

  // ===========================================================
  // Bus idle synchroniser

  // Pin level crosses in; stage one feeds only stage two
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      idle_s1_reg <= 1'b1;
      idle_s2_reg <= 1'b1;
      idle_s3_reg <= 1'b1;
    end
    else if (ce)
    begin
      idle_s1_reg <= line_idle;
      idle_s2_reg <= idle_s1_reg;
      idle_s3_reg <= idle_s2_reg;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      idle_reg <= 1'b1;
    else if (ce && (idle_s2_reg == idle_s3_reg))
      idle_reg <= idle_s2_reg;
  end

  // Previous settled level; preset to idle so that leaving reset
  // does not look like the start of a reply
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      idle_q_reg <= 1'b1;
    else if (ce)
      idle_q_reg <= idle_reg;
  end

  // Only a move out of idle ends the gap. The settled level lags the
  // pin by several cycles, so right after an end of packet it may
  // still show the packet's own traffic; a level test would cancel
  // every gap at once and no timeout could ever be flagged.
  assign idle_fall = idle_q_reg && !idle_reg;

  // ===========================================================
  // Turnaround timer

  // Armed by an end of packet when the other side must reply:
  // token to data on SETUP/OUT, data to handshake on IN.
  // The count runs from arming whatever the settled level shows;
  // only a move out of idle ends the gap. A reply that lands within
  // the synchroniser lag of the limit is still counted as late.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      turn_state_reg <= TURN_OFF;
      turn_cnt_reg   <= TURN_CNT_ZERO;
    end
    else if (ce)
    begin
      case (turn_state_reg)
        TURN_OFF:
        begin
          turn_cnt_reg <= TURN_CNT_ZERO;
          if (eop_seen && await_resp)
            turn_state_reg <= TURN_ARMED;
        end
        TURN_ARMED:
        begin
          if (idle_fall)
          begin
            // Reply began in time
            turn_state_reg <= TURN_OFF;
            turn_cnt_reg   <= TURN_CNT_ZERO;
          end
          else if (turn_cnt_reg >= TURN_CNT_W'(TURN_CYCLES))
            turn_state_reg <= TURN_DONE;
          else
            turn_cnt_reg <= turn_cnt_reg + TURN_CNT_ONE;
        end
        TURN_DONE:
        begin
          // One fault per gap, then wait for the next packet end
          turn_state_reg <= TURN_OFF;
          turn_cnt_reg   <= TURN_CNT_ZERO;
        end
        default:
        begin
          turn_state_reg <= TURN_OFF;
          turn_cnt_reg   <= TURN_CNT_ZERO;
        end
      endcase
    end
  end

  // Fault in the cycle the gap is found too long
  assign turn_fault = (turn_state_reg == TURN_DONE);

  // ===========================================================
  // Buffer size check

  // Counts stored bytes; bytes beyond the descriptor size are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      byte_cnt_reg <= '0;
    else if (ce)
    begin
      if (pkt_start)
        byte_cnt_reg <= '0;
      else if (rx_byte && !oversize)
        byte_cnt_reg <= byte_cnt_reg + BD_SIZE_W'(1);
    end
  end

  assign oversize = (byte_cnt_reg >= bd_size);

  // Store strobe follows the byte by one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      store_en <= 1'b0;
    else if (ce)
      store_en <= rx_byte && !oversize && !pkt_start;
  end

  // ===========================================================
  // Error events

  // Each event lands in its flag the cycle after detection,
  // independent of where the token is in its processing
  always_comb
  begin
    err_set = ZERO8;
    if (det.bit_stuff)
      err_set = err_set | bit_of(BIT_STUFF);
    if (det.bd_late)
      err_set = err_set | bit_of(BIT_BUF);
    if (rx_byte && oversize && !pkt_start)
      err_set = err_set | bit_of(BIT_BUF);
    if (turn_fault)
      err_set = err_set | bit_of(BIT_TURN);
    if (det.partial_byte)
      err_set = err_set | bit_of(BIT_PARTBYTE);
    if (det.data_crc)
      err_set = err_set | bit_of(BIT_DATCRC);
    if (det.token_crc)
      err_set = err_set | bit_of(BIT_TOKCRC);
    if (det.pid)
      err_set = err_set | bit_of(BIT_PID);
  end

  // ===========================================================
  // Error flag register

  assign err_flags_next = w1c_next(err_flags_reg, flag_clr,
                                   err_set, ERR_IMPL_MASK);

  // Sticky; a write of one clears, a new event in that cycle wins
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      err_flags_reg <= ERR_FLAGS_RST;
    else if (ce)
      err_flags_reg <= err_flags_next;
  end

  // ===========================================================
  // Error enable register

  // Plain read/write; bit 6 has no storage
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      err_enab_reg <= ERR_ENAB_RST;
    else if (ce && bus_req.wr && (bus_req.addr == ADDR_ERR_ENAB))
      err_enab_reg <= bus_req.wdata & ERR_IMPL_MASK;
  end

  // ===========================================================
  // Interrupt status and enable

  // Error bit is re-set every cycle an enabled flag stands, so
  // clearing it only sticks once the flags themselves are cleared
  always_comb
  begin
    int_set = ZERO8;
    int_set[BIT_INT_ERR] = |(err_flags_reg & err_enab_reg);
  end

  assign int_stat_next = w1c_next(int_stat_reg, int_clr,
                                  int_set, INT_IMPL_MASK);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      int_stat_reg <= INT_STAT_RST;
    else if (ce)
      int_stat_reg <= int_stat_next;
  end

  // Only the error source lives here; other bits read zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      int_enab_reg <= INT_ENAB_RST;
    else if (ce && bus_req.wr && (bus_req.addr == ADDR_INT_ENAB))
      int_enab_reg <= bus_req.wdata & INT_IMPL_MASK;
  end

  // Registered request from the next status, so it moves with the status bits
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else if (ce)
      irq <= |(int_stat_next & int_enab_reg);
  end

  // ===========================================================
  // Packet rejection

  // Decoder drops the packet on these one-cycle outputs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pkt_reject <= 1'b0;
      tok_reject <= 1'b0;
    end
    else if (ce)
    begin
      pkt_reject <= det.bit_stuff || det.data_crc;
      tok_reject <= det.token_crc;
    end
  end

  // ===========================================================
  // Read port

  // Data stand the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      bus_rdata <= ZERO8;
    else if (ce)
    begin
      if (bus_req.rd)
      begin
        case (bus_req.addr)
          ADDR_ERR_FLAGS: bus_rdata <= err_flags_reg;
          ADDR_ERR_ENAB:  bus_rdata <= err_enab_reg;
          ADDR_INT_STAT:  bus_rdata <= int_stat_reg;
          ADDR_INT_ENAB:  bus_rdata <= int_enab_reg;
          default:        bus_rdata <= ZERO8;
        endcase
      end
      else
        bus_rdata <= ZERO8;
    end
  end

endmodule // ufe_error_flag_unit

// >>> ufe_error_flag_unit_properties.sv
// Checker: port-level properties of the error flag unit.
// Assumes ce is held high and one clock domain.
`timescale 1ns/10ps
module ufe_error_flag_unit_properties
  import ufe_pkg::*;
#(
  parameter int BD_SIZE_W = 10             // Descriptor size width
)
(
  input wire logic                 clk,        // Clock
  input wire logic                 rst_b,      // Sync reset
  input wire logic                 ce,         // Clock enable
  input wire ufe_bus_req_t         bus_req,    // Register request
  input wire logic [7:0]           bus_rdata,  // Read data
  input wire ufe_det_t             det,        // Detections
  input wire logic                 pkt_start,  // Packet start
  input wire logic                 rx_byte,    // Byte strobe
  input wire logic [BD_SIZE_W-1:0] bd_size,    // Descriptor size
  input wire logic                 eop_seen,   // End of packet
  input wire logic                 await_resp, // Reply expected
  input wire logic                 line_idle,  // Bus idle
  input wire logic                 store_en,   // Byte stored
  input wire logic                 pkt_reject, // Packet dropped
  input wire logic                 tok_reject, // Token dropped
  input wire logic                 irq         // Interrupt
);
  // =====
  // Sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence rd_flags;
    bus_req.rd && bus_req.addr == ADDR_ERR_FLAGS;
  endsequence
  sequence bad_pkt;
    det.bit_stuff || det.data_crc;
  endsequence
  // =====
  // Properties
  a_bit6_zero: assert property (
    bus_req.rd |=> !bus_rdata[6]) else $error("bit 6 read as one");
  a_tok_reject: assert property (
    det.token_crc |=> tok_reject) else $error("token not rejected");
  a_pkt_reject: assert property (
    bad_pkt |=> pkt_reject) else $error("packet not rejected");
  a_reject_cause: assert property (
    pkt_reject |-> $past(det.bit_stuff) || $past(det.data_crc))
    else $error("packet rejected without cause");
  a_store_cause: assert property (
    store_en |-> $past(rx_byte) && !$past(pkt_start))
    else $error("store without byte");
  a_irq_fall: assert property (
    $fell(irq) |-> $past(bus_req.wr) || $past(bus_req.wr, 2)
    || $past(bus_req.wr, 3)) else $error("irq fell without write");
  a_pid_flag: assert property (
    det.pid ##[1:4] rd_flags |=> bus_rdata[BIT_PID])
    else $error("pid flag missing");
  a_stuff_flag: assert property (
    det.bit_stuff ##[1:4] rd_flags |=> bus_rdata[BIT_STUFF])
    else $error("stuff flag missing");
endmodule // ufe_error_flag_unit_properties

bind ufe_error_flag_unit ufe_error_flag_unit_properties
  #(.BD_SIZE_W(BD_SIZE_W)) u_props (.clk(clk), .rst_b(rst_b),
  .ce(ce), .bus_req(bus_req), .bus_rdata(bus_rdata), .det(det),
  .pkt_start(pkt_start), .rx_byte(rx_byte), .bd_size(bd_size),
  .eop_seen(eop_seen), .await_resp(await_resp),
  .line_idle(line_idle), .store_en(store_en),
  .pkt_reject(pkt_reject), .tok_reject(tok_reject), .irq(irq));

// >>> ufe_host_model.sv
// Host model: busy with packet traffic outside a gap, idle from an
// end of packet for gap cycles, then eight cycles of reply.
// Assumes the bench sets gap before pulsing end of packet.
`timescale 1ns/10ps
module ufe_host_model
(
  input  wire logic        clk,       // Clock
  input  wire logic        eop_seen,  // End of packet
  input  wire logic [15:0] gap,       // Reply delay in cycles
  output logic             line_idle  // Bus idle level
);
  int cnt = 0;
  // Count from end of packet; a slow host simply waits longer
  always_ff @(posedge clk)
  begin
    if (eop_seen)
      cnt <= 1;
    else if (cnt != 0)
      cnt <= (cnt == int'(gap) + 8) ? 0 : cnt + 1;
  end
  // The line shows traffic right up to the end of packet, as a real
  // bus does, so the block must ride out its own synchroniser lag
  assign line_idle = (cnt != 0) && (cnt <= int'(gap));
endmodule // ufe_host_model

// >>> usb_error_flag_unit_tb.sv
// Testbench for the USB error flag unit.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/10ps
module usb_error_flag_unit_tb;
  import ufe_pkg::*;
  logic         clk, rst_b, pkt_start, rx_byte, eop_seen, await_resp;
  logic         line_idle, store_en, pkt_reject, tok_reject, irq;
  ufe_bus_req_t bus_req;
  ufe_det_t     det;
  logic [9:0]   bd_size;
  logic [7:0]   bus_rdata;
  logic [15:0]  gap;
  int           errors, tests_run;
  localparam int FBIT [6] = '{BIT_BUF, BIT_PARTBYTE, BIT_PID,
                              BIT_TOKCRC, BIT_DATCRC, BIT_STUFF};

  ufe_error_flag_unit dut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .det(det),
    .pkt_start(pkt_start), .rx_byte(rx_byte), .bd_size(bd_size),
    .eop_seen(eop_seen), .await_resp(await_resp),
    .line_idle(line_idle), .store_en(store_en),
    .pkt_reject(pkt_reject), .tok_reject(tok_reject), .irq(irq));
  ufe_host_model host (.clk(clk), .eop_seen(eop_seen), .gap(gap),
    .line_idle(line_idle));

  // =====
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) bus_req <= '{a, v, 1'b0, 1'b0};
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus_req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 chk(bus_rdata, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk) det <= ufe_det_t'(6'h01 << i);
    @(posedge clk) det <= '0;
  endtask
  task automatic wait_chk_irq(input int n, input logic exp);
    repeat (n) @(posedge clk);
    #1 chk({7'h00, irq}, {7'h00, exp});
  endtask

  // =====
  // Scenarios
  task automatic t_reset;
    rc(ADDR_ERR_FLAGS, ERR_FLAGS_RST);
    wr(ADDR_ERR_FLAGS, 8'hff);
    rc(ADDR_ERR_FLAGS, 8'h00);
    rc(4'h9, 8'h00);
  endtask
  task automatic t_flags;
    logic [7:0] e;
    logic [7:0] r;
    for (int i = 0; i < 6; i++)
    begin
      e = 8'h01 << FBIT[i];
      r = {6'h00, i >= 4, i == 3};
      pulse(i);
      #1 chk({6'h00, pkt_reject, tok_reject}, r);
      rc(ADDR_ERR_FLAGS, e);
      wr(ADDR_ERR_FLAGS, ~e);
      rc(ADDR_ERR_FLAGS, e);
      wr(ADDR_ERR_FLAGS, e);
      rc(ADDR_ERR_FLAGS, 8'h00);
    end
  endtask
  task automatic t_enab;
    wr(ADDR_ERR_ENAB, 8'hff);
    rc(ADDR_ERR_ENAB, ERR_IMPL_MASK);
    wr(ADDR_INT_ENAB, 8'hff);
    rc(ADDR_INT_ENAB, INT_IMPL_MASK);
    wr(ADDR_ERR_ENAB, 8'h00);
    pulse(2);
    wait_chk_irq(4, 1'b0);
    wr(ADDR_ERR_ENAB, 8'h01);
    wait_chk_irq(4, 1'b1);
    rc(ADDR_INT_STAT, 8'h02);
    wr(ADDR_ERR_FLAGS, 8'h01);
    wr(ADDR_INT_STAT, 8'h02);
    wait_chk_irq(3, 1'b0);
  endtask
  // Third byte overflows a two-byte buffer
  task automatic t_buf;
    @(posedge clk) bd_size <= 10'h002;
    pkt_start <= 1'b1;
    @(posedge clk) pkt_start <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk) rx_byte <= 1'b1;
      @(posedge clk) rx_byte <= 1'b0;
      #1 chk({7'h00, store_en}, {7'h00, i < 2});
    end
    rc(ADDR_ERR_FLAGS, 8'h20);
    wr(ADDR_ERR_FLAGS, 8'hff);
  endtask
  task automatic turn(input int g, input logic r, input logic [7:0] e);
    @(posedge clk) gap <= g[15:0];
    eop_seen <= 1'b1;
    await_resp <= r;
    @(posedge clk) eop_seen <= 1'b0;
    repeat (250) @(posedge clk);
    rc(ADDR_ERR_FLAGS, e);
    wr(ADDR_ERR_FLAGS, 8'hff);
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #160000;
    errors++;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    bus_req = '0;
    det = '0;
    {pkt_start, rx_byte, eop_seen, await_resp} = 4'h0;
    bd_size = '0;
    gap = '0;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_flags;
    t_enab;
    t_buf;
    turn(40, 1'b1, 8'h00);
    turn(400, 1'b1, 8'h10);
    turn(400, 1'b0, 8'h00);
    end_of_test;
  end
endmodule // usb_error_flag_unit_tb
